// >>> svmc_monitor.sv
// supply voltage monitor control, event flag and interrupt logic
`timescale 1ns/1ns
`default_nettype none
module svmc_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   // classic wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // analog side
   input wire logic supply_above_i,
   input wire logic ext_above_i,
   input wire logic bandgap_stable_i,
   output logic monitor_power_o,
   output logic [3:0] trip_level_o,
   output logic ext_input_sel_o,
   // system side
   input wire logic sleep_i,
   output logic irq_o,
   output logic event_priority_o,
   output logic wake_o,
   output logic resume_at_vector_o
);
   import svmc_pkg::*;

   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic direction_select;
      logic monitor_enable;
      logic [3:0] trip_level_select;
      logic voltage_event_flag;
      logic voltage_event_irq_enable;
      logic voltage_event_priority;
      logic global_irq_enable;
      svmc_mode_t mode;
   } svmc_state_t;

   svmc_state_t st;
   svmc_state_t next_st;

   logic settle_done;
   logic req;
   logic wr_commit;
   logic wr_control;
   logic wr_flags;
   logic wr_irq_en;
   logic wr_priority;
   logic wr_intctl;
   logic reference_stable;
   logic cmp_above;
   logic trip_seen;
   logic event_hit;
   logic [7:0] control_view;
   logic [31:0] read_mux;

   // reference settles for a fixed time after each enable
   svmc_settle_timer u_settle (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(st.mode == SVMC_SETTLING),
      .done_o(settle_done)
   );

   // bus decode; writes commit on the edge where ack is sampled high
   assign req = wb_cyc_i & wb_stb_i;
   assign wr_commit = req & wb_we_i & st.ack & wb_sel_i[0];
   assign wr_control = wr_commit & (wb_adr_i == SVMC_OFF_CONTROL);
   assign wr_flags = wr_commit & (wb_adr_i == SVMC_OFF_FLAGS);
   assign wr_irq_en = wr_commit & (wb_adr_i == SVMC_OFF_IRQ_EN);
   assign wr_priority = wr_commit & (wb_adr_i == SVMC_OFF_PRIORITY);
   assign wr_intctl = wr_commit & (wb_adr_i == SVMC_OFF_INTCTL);

   // reference stable is pure status, no write path reaches it
   assign reference_stable = (st.mode == SVMC_ARMED);

   // external pin replaces the divider tap at the top level code
   assign cmp_above = (st.trip_level_select == SVMC_LEVEL_EXTERNAL) ?
      ext_above_i : supply_above_i;

   // direction picks rise above or fall below the trip point
   assign trip_seen = st.direction_select ? cmp_above : ~cmp_above;

   // nothing is seen until settling is over, sleep does not stop it
   assign event_hit = reference_stable & trip_seen;

   // control register as software sees it
   always_comb begin
      control_view = 8'h00;
      control_view[SVMC_BIT_DIR] = st.direction_select;
      control_view[SVMC_BIT_BGSTABLE] = bandgap_stable_i;
      control_view[SVMC_BIT_REFSTABLE] = reference_stable;
      control_view[SVMC_BIT_ENABLE] = st.monitor_enable;
      control_view[SVMC_LEVEL_MSB:0] = st.trip_level_select;
   end

   // read multiplexer; unmapped offsets read as zero
   always_comb begin
      read_mux = SVMC_DATA_ZERO;
      case (wb_adr_i)
         SVMC_OFF_CONTROL: begin
            read_mux[7:0] = control_view;
         end
         SVMC_OFF_FLAGS: begin
            read_mux[SVMC_BIT_EVENT] = st.voltage_event_flag;
         end
         SVMC_OFF_IRQ_EN: begin
            read_mux[SVMC_BIT_EVENT] = st.voltage_event_irq_enable;
         end
         SVMC_OFF_PRIORITY: begin
            read_mux[SVMC_BIT_EVENT] = st.voltage_event_priority;
         end
         SVMC_OFF_INTCTL: begin
            read_mux[SVMC_BIT_GIE] = st.global_irq_enable;
         end
         default: begin
            read_mux = SVMC_DATA_ZERO;
         end
      endcase
   end

   // next state of everything the block remembers
   always_comb begin
      next_st = st;
      // single ack per request, dropped the cycle after
      next_st.ack = req & ~st.ack;
      if (req & ~st.ack) begin
         next_st.rdata = read_mux;
      end

      // configuration is accepted at any time; software is expected
      // to switch off first so the trip point never glitches live
      if (wr_control) begin
         next_st.direction_select = wb_dat_i[SVMC_BIT_DIR];
         next_st.monitor_enable = wb_dat_i[SVMC_BIT_ENABLE];
         next_st.trip_level_select = wb_dat_i[SVMC_LEVEL_MSB:0];
      end
      if (wr_irq_en) begin
         next_st.voltage_event_irq_enable = wb_dat_i[SVMC_BIT_EVENT];
      end
      if (wr_priority) begin
         next_st.voltage_event_priority = wb_dat_i[SVMC_BIT_EVENT];
      end
      if (wr_intctl) begin
         next_st.global_irq_enable = wb_dat_i[SVMC_BIT_GIE];
      end

      // power sequence: every enable restarts settling
      case (st.mode)
         SVMC_OFF: begin
            if (st.monitor_enable) begin
               next_st.mode = SVMC_SETTLING;
            end
         end
         SVMC_SETTLING: begin
            if (!st.monitor_enable) begin
               next_st.mode = SVMC_OFF;
            end else if (settle_done) begin
               next_st.mode = SVMC_ARMED;
            end
         end
         SVMC_ARMED: begin
            if (!st.monitor_enable) begin
               next_st.mode = SVMC_OFF;
            end
         end
         default: begin
            next_st.mode = SVMC_OFF;
         end
      endcase

      // sticky flag, write one clears, a new event wins the clear
      if (wr_flags & wb_dat_i[SVMC_BIT_EVENT]) begin
         next_st.voltage_event_flag = 1'b0;
      end
      if (event_hit) begin
         next_st.voltage_event_flag = 1'b1;
      end
   end

   // state register; reset leaves the monitor off
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
         st.direction_select <= SVMC_RST_DIR;
         st.monitor_enable <= SVMC_RST_ENABLE;
         st.trip_level_select <= SVMC_RST_LEVEL;
         st.voltage_event_flag <= SVMC_RST_FLAG;
         st.voltage_event_irq_enable <= SVMC_RST_IRQ_EN;
         st.voltage_event_priority <= SVMC_RST_PRIORITY;
         st.global_irq_enable <= SVMC_RST_GIE;
         st.mode <= SVMC_OFF;
      end else begin
         st <= next_st;
      end
   end

   // bus outputs
   assign wb_ack_o = st.ack;
   assign wb_dat_o = st.rdata;

   // analog controls follow the stored configuration
   assign monitor_power_o = st.monitor_enable;
   assign trip_level_o = st.trip_level_select;
   assign ext_input_sel_o = (st.trip_level_select == SVMC_LEVEL_EXTERNAL);

   // interrupt needs both enables and a settled reference
   assign irq_o = st.voltage_event_flag & st.voltage_event_irq_enable
      & st.global_irq_enable & reference_stable;
   assign event_priority_o = st.voltage_event_priority;

   // the flag alone wakes the core; vector only with interrupts on
   assign wake_o = sleep_i & st.voltage_event_flag;
   assign resume_at_vector_o = wake_o & st.voltage_event_irq_enable
      & st.global_irq_enable;
endmodule : svmc_monitor
`default_nettype wire

// >>> svmc_pkg.sv
// package of constants and types for the supply voltage monitor controller
package svmc_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] SVMC_OFF_CONTROL = 8'h00;
   localparam logic [7:0] SVMC_OFF_FLAGS = 8'h04;
   localparam logic [7:0] SVMC_OFF_IRQ_EN = 8'h08;
   localparam logic [7:0] SVMC_OFF_PRIORITY = 8'h0c;
   localparam logic [7:0] SVMC_OFF_INTCTL = 8'h10;
   // control register field positions
   localparam int SVMC_BIT_DIR = 7;
   localparam int SVMC_BIT_BGSTABLE = 6;
   localparam int SVMC_BIT_REFSTABLE = 5;
   localparam int SVMC_BIT_ENABLE = 4;
   localparam int SVMC_LEVEL_MSB = 3;
   // event bit in flag, enable and priority registers
   localparam int SVMC_BIT_EVENT = 2;
   // global enable in interrupt control register
   localparam int SVMC_BIT_GIE = 7;
   // level code that routes the external trip input
   localparam logic [3:0] SVMC_LEVEL_EXTERNAL = 4'hf;
   // values after reset
   localparam logic SVMC_RST_DIR = 1'b0;
   localparam logic SVMC_RST_ENABLE = 1'b0;
   localparam logic [3:0] SVMC_RST_LEVEL = 4'h0;
   localparam logic SVMC_RST_FLAG = 1'b0;
   localparam logic SVMC_RST_IRQ_EN = 1'b0;
   localparam logic SVMC_RST_PRIORITY = 1'b0;
   localparam logic SVMC_RST_GIE = 1'b0;
   // reference settling time, converted to a cycle count for a fixed 10 ns clock period
   localparam int SVMC_CLK_PERIOD_NS = 10;
   localparam int SVMC_REF_SETTLE_NS = 20000;
   localparam int SVMC_SETTLE_CYCLES_INT =
      (SVMC_REF_SETTLE_NS + SVMC_CLK_PERIOD_NS - 1) / SVMC_CLK_PERIOD_NS;
   localparam int SVMC_CNT_W = 12;
   localparam logic [SVMC_CNT_W-1:0] SVMC_SETTLE_LAST =
      SVMC_CNT_W'(SVMC_SETTLE_CYCLES_INT - 1);
   localparam logic [SVMC_CNT_W-1:0] SVMC_CNT_ZERO = 12'h000;
   localparam logic [31:0] SVMC_DATA_ZERO = 32'h0000_0000;

   // monitor power and settling sequence
   typedef enum logic [1:0] {
      SVMC_OFF,
      SVMC_SETTLING,
      SVMC_ARMED
   } svmc_mode_t;
endpackage : svmc_pkg

// >>> svmc_settle_timer.sv
// settling interval timer for the monitor reference
`timescale 1ns/1ns
`default_nettype none
module svmc_settle_timer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   output logic done_o
);
   import svmc_pkg::*;

   typedef struct packed {
      logic [SVMC_CNT_W-1:0] count;
      logic done;
   } svmc_timer_state_t;

   svmc_timer_state_t st;
   svmc_timer_state_t next_st;

   // count while running, restart from zero whenever run drops
   always_comb begin
      next_st = st;
      if (!run_i) begin
         next_st.count = SVMC_CNT_ZERO;
         next_st.done = 1'b0;
      end else if (!st.done) begin
         if (st.count == SVMC_SETTLE_LAST) begin
            next_st.done = 1'b1;
         end else begin
            next_st.count = st.count + 12'h001;
         end
      end
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign done_o = st.done;
endmodule : svmc_settle_timer
`default_nettype wire

// >>> svmc_monitor_asserts.sv
// port-level assertions for the supply voltage monitor
`timescale 1ns/1ns
`default_nettype none
module svmc_monitor_asserts (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic wb_ack_o,
   input wire logic [3:0] trip_level_o,
   input wire logic ext_input_sel_o,
   input wire logic monitor_power_o,
   input wire logic sleep_i,
   input wire logic irq_o,
   input wire logic wake_o,
   input wire logic resume_at_vector_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // every taken request is answered on the next cycle
   property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("ack missing");
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_ext_sel; ext_input_sel_o == (trip_level_o == 4'hf); endproperty
   a_ext_sel: assert property (p_ext_sel) else $error("external select wrong");
   // reset must win even while disabled, so this one ignores the default
   property p_reset_off;
      disable iff (1'b0) rst_i |=> !monitor_power_o && !irq_o && !wb_ack_o;
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("reset left monitor on");
   property p_settle_quiet; $rose(monitor_power_o) |-> !irq_o [*8]; endproperty
   a_settle_quiet: assert property (p_settle_quiet) else $error("irq while settling");
   // only a bus write may clear a set flag
   property p_sticky; wake_o && !(wb_cyc_i && wb_we_i) ##1 sleep_i |-> wake_o; endproperty
   a_sticky: assert property (p_sticky) else $error("flag lost");
   property p_vector; resume_at_vector_o |-> wake_o; endproperty
   a_vector: assert property (p_vector) else $error("vector without wake");
   property p_wake_sleep; wake_o |-> sleep_i; endproperty
   a_wake_sleep: assert property (p_wake_sleep) else $error("wake while awake");
   property p_irq_power; irq_o |-> $past(monitor_power_o); endproperty
   a_irq_power: assert property (p_irq_power) else $error("irq while off");
endmodule : svmc_monitor_asserts

bind svmc_monitor svmc_monitor_asserts svmc_monitor_asserts_i (.clk_i, .rst_i, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_ack_o, .trip_level_o, .ext_input_sel_o, .monitor_power_o,
   .sleep_i, .irq_o, .wake_o, .resume_at_vector_o);
`default_nettype wire

// >>> svmc_monitor_tb.sv
// self-checking bench for the supply voltage monitor
`timescale 1ns/1ns
`default_nettype none
module svmc_monitor_tb;
   import svmc_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, sup = 1'b0, ext = 1'b0;
   logic bg = 1'b1, slp = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, dat_o;
   logic ack, pwr, xsel, irq, pri, wake, vec;
   logic [3:0] lvl, lv;
   int n_fail = 0, comparisons = 0;
   svmc_monitor svmc_monitor_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .supply_above_i(sup), .ext_above_i(ext), .bandgap_stable_i(bg),
      .monitor_power_o(pwr), .trip_level_o(lvl), .ext_input_sel_o(xsel), .sleep_i(slp),
      .irq_o(irq), .event_priority_o(pri), .wake_o(wake), .resume_at_vector_o(vec));
   always #5 clk_i = ~clk_i;
   // one classic cycle; the wait is bounded so a dead slave cannot hang us
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      int t;
      t = 0;
      cyc <= 1'b1; we <= w; adr <= a; wdat <= {24'h0, d};
      @(posedge clk_i);
      while (ack !== 1'b1 && t < 50) begin
         @(posedge clk_i);
         t++;
      end
      check("ack", 32'h1, {31'h0, ack});
      rdat = dat_o;
      cyc <= 1'b0; we <= 1'b0;
      @(posedge clk_i);
   endtask : bus
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : check
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 8'h00);
      check(nm, e, rdat);
   endtask : rd
   task automatic summarize;
      if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   // guard against a hang; the tests need well under half of this
   initial begin
      #200000;
      n_fail++;
      summarize();
   end
   initial begin
      lv = 4'($urandom(32'ha77f2f36));
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(SVMC_OFF_CONTROL, 32'h40, "ctrl_reset");
      rd(8'h14, 32'h0, "unmapped");
      // random levels with the monitor off
      repeat (4) begin
         lv = 4'($urandom());
         bus(1'b1, SVMC_OFF_CONTROL, {4'h0, lv});
         check("level", {28'h0, lv}, {28'h0, lvl});
         check("ext_sel", {31'h0, lv == 4'hf}, {31'h0, xsel});
      end
      lv = 4'($urandom() % 15);
      bus(1'b1, SVMC_OFF_CONTROL, {4'h8, lv});
      bus(1'b1, SVMC_OFF_CONTROL, {4'h9, lv});
      check("power", 32'h1, {31'h0, pwr});
      sup <= 1'b1;
      repeat (100) @(posedge clk_i);
      rd(SVMC_OFF_FLAGS, 32'h0, "flag_settling");
      rd(SVMC_OFF_CONTROL, {24'h0, 4'hd, lv}, "ctrl_settling");
      repeat (2000) @(posedge clk_i);
      rd(SVMC_OFF_CONTROL, {24'h0, 4'hf, lv}, "ctrl_stable");
      rd(SVMC_OFF_FLAGS, 32'h4, "flag_rise");
      bus(1'b1, SVMC_OFF_IRQ_EN, 8'h04);
      check("irq_no_gie", 32'h0, {31'h0, irq});
      bus(1'b1, SVMC_OFF_INTCTL, 8'h80);
      check("irq_on", 32'h1, {31'h0, irq});
      sup <= 1'b0;
      repeat (3) @(posedge clk_i);
      check("irq_sticky", 32'h1, {31'h0, irq});
      bus(1'b1, SVMC_OFF_FLAGS, 8'h04);
      check("irq_clear", 32'h0, {31'h0, irq});
      // falling direction while asleep
      bus(1'b1, SVMC_OFF_CONTROL, {4'h1, lv});
      slp <= 1'b1;
      repeat (2) @(posedge clk_i);
      check("wake", 32'h1, {31'h0, wake});
      check("vector", 32'h1, {31'h0, vec});
      bus(1'b1, SVMC_OFF_INTCTL, 8'h00);
      check("vector_no_gie", 32'h0, {31'h0, vec});
      check("irq_no_gie2", 32'h0, {31'h0, irq});
      slp <= 1'b0;
      sup <= 1'b1;
      bus(1'b1, SVMC_OFF_FLAGS, 8'h04);
      rd(SVMC_OFF_FLAGS, 32'h0, "flag_fall_dir");
      bus(1'b1, SVMC_OFF_PRIORITY, 8'h04);
      check("priority", 32'h1, {31'h0, pri});
      // external trip input
      bus(1'b1, SVMC_OFF_CONTROL, 8'h9f);
      check("ext_sel_on", 32'h1, {31'h0, xsel});
      rd(SVMC_OFF_FLAGS, 32'h0, "flag_ext_low");
      ext <= 1'b1;
      repeat (2) @(posedge clk_i);
      rd(SVMC_OFF_FLAGS, 32'h4, "flag_ext_high");
      // check done, switch off; the flag is left set on purpose
      bus(1'b1, SVMC_OFF_CONTROL, 8'h8f);
      check("power_off", 32'h0, {31'h0, pwr});
      rd(SVMC_OFF_CONTROL, 32'hcf, "ctrl_off");
      // all enables on and a stale flag, yet settling must keep irq low
      bus(1'b1, SVMC_OFF_INTCTL, 8'h80);
      bus(1'b1, SVMC_OFF_CONTROL, 8'h9f);
      repeat (8) @(posedge clk_i);
      check("irq_settling", 32'h0, {31'h0, irq});
      rd(SVMC_OFF_FLAGS, 32'h4, "flag_kept");
      // reset in mid-run
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check("power_reset", 32'h0, {31'h0, pwr});
      rd(SVMC_OFF_CONTROL, 32'h40, "ctrl_rerst");
      rd(SVMC_OFF_FLAGS, 32'h0, "flag_rerst");
      bg <= 1'b0;
      rd(SVMC_OFF_CONTROL, 32'h00, "ctrl_bg_low");
      summarize();
   end
endmodule : svmc_monitor_tb
`default_nettype wire
